// ===== timer_ch4_consts.svh
// register offsets, field positions, reset values and codes of the channel-4 i/o control block
// assumes it is included by bare name from every file that needs a number
`ifndef TIMER_CH4_CONSTS_SVH
`define TIMER_CH4_CONSTS_SVH

// ----------------------------------------
// bus geometry
// ----------------------------------------
`define ADDR_W 4
`define DATA_W 16
`define CNT_W 16

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_IO_CTRL_HIGH 4'h0
`define OFS_IO_CTRL_LOW 4'h1
`define OFS_MODE 4'h2
`define OFS_REG_A 4'h3
`define OFS_REG_B 4'h4
`define OFS_REG_C 4'h5
`define OFS_REG_D 4'h6
`define OFS_STATUS 4'h7
`define OFS_MASK 4'h8
`define OFS_PIN_STATE 4'h9

// ----------------------------------------
// field layout and codes
// ----------------------------------------
`define FIELD_LO_MSB 3
`define FIELD_HI_LSB 4
`define FIELD_HI_MSB 7
`define FIELD_CAPTURE_BIT 3
`define FIELD_INIT_BIT 2
`define ACT_NONE 2'h0
`define ACT_LOW 2'h1
`define ACT_HIGH 2'h2
`define ACT_TOGGLE 2'h3
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define MODE_BUF_A_BIT 0
`define MODE_BUF_B_BIT 1

// ----------------------------------------
// reset values and channel indices
// ----------------------------------------
`define RST_FIELD 4'h0
`define RST_CTRL 8'h00
`define RST_MODE 2'h0
`define RST_REG 16'h0000
`define RST_STATUS 8'h00
`define RST_MASK 8'h00
`define CH_A 0
`define CH_B 1
`define CH_C 2
`define CH_D 3
`define NUM_CH 4

`endif

// ===== timer_ch4_pkg.sv
// types shared by the channel-4 i/o control block
// assumes timer_ch4_consts.svh is on the include path
`include "timer_ch4_consts.svh"

package timer_ch4_pkg;

   // one compare/capture slot
   typedef struct packed {
      logic [3:0] field_prev;
      logic pin_prev;
      logic pin_lvl;
      logic pin_oe;
   } chan_state_t;

   typedef struct packed {
      logic [7:0] ctrl_hi;
      logic [7:0] ctrl_lo;
      logic [1:0] mode;
      logic [`NUM_CH*`DATA_W-1:0] regs;
      logic [7:0] status;
      logic [7:0] mask;
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [`DATA_W-1:0] rdata;
      logic irq;
   } top_state_t;

endpackage

// ===== timer_ch4_chan_if.sv
// carrier between the control top and one compare/capture slot
// assumes both ends run on the same clock
`timescale 1ns/1ps
`include "timer_ch4_consts.svh"

interface timer_ch4_chan_if;
   logic [3:0] field;
   logic inhibit;
   logic [`CNT_W-1:0] count;
   logic count_tick;
   logic [`DATA_W-1:0] value;
   logic pin_in;
   logic pin_out;
   logic pin_oe;
   logic capture;
   logic match;

   modport top (output field, inhibit, count, count_tick, value, pin_in, input pin_out, pin_oe, capture, match);
   modport slot (input field, inhibit, count, count_tick, value, pin_in, output pin_out, pin_oe, capture, match);
endinterface

// ===== timer_ch4_chan.sv
// one compare/capture slot: pin drive in compare mode, edge detection in capture mode
// assumes pin_in is already synchronised and count/value come from the same clock
`timescale 1ns/1ps
`include "timer_ch4_consts.svh"

module timer_ch4_chan (
   input wire logic clock, // 25 MHz
   input wire logic reset_n, // async, active low
   timer_ch4_chan_if.slot port // slot side of carrier
);

   timer_ch4_pkg::chan_state_t s_r;
   timer_ch4_pkg::chan_state_t s_nxt;
   logic [3:0] fld;
   logic rise;
   logic fall;
   logic cmp_hit;

   // buffered slot behaves as output disabled
   assign fld = port.inhibit ? `RST_FIELD : port.field;
   assign rise = port.pin_in & ~s_r.pin_prev;
   assign fall = ~port.pin_in & s_r.pin_prev;
   assign cmp_hit = port.count_tick && (port.count == port.value);

   assign port.match = ~port.inhibit & ~fld[`FIELD_CAPTURE_BIT] & cmp_hit;
   assign port.capture = ~port.inhibit & fld[`FIELD_CAPTURE_BIT]
      & ((fld[1:0] == `EDGE_RISE) & rise
      | (fld[1:0] == `EDGE_FALL) & fall
      | fld[1] & (rise | fall));
   assign port.pin_out = s_r.pin_lvl;
   assign port.pin_oe = s_r.pin_oe;

   always_comb begin
      s_nxt = s_r;
      s_nxt.pin_prev = port.pin_in;
      s_nxt.field_prev = fld;
      s_nxt.pin_oe = ~fld[`FIELD_CAPTURE_BIT] & (fld[1:0] != `ACT_NONE);
      if (fld != s_r.field_prev) begin
         // new setting loads the level seen before the first match
         s_nxt.pin_lvl = fld[`FIELD_INIT_BIT];
      end else if (port.match) begin
         unique case (fld[1:0])
            `ACT_NONE: s_nxt.pin_lvl = s_r.pin_lvl;
            `ACT_LOW: s_nxt.pin_lvl = 1'b0;
            `ACT_HIGH: s_nxt.pin_lvl = 1'b1;
            `ACT_TOGGLE: s_nxt.pin_lvl = ~s_r.pin_lvl;
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule // timer_ch4_chan

// ===== timer_ch4_io_control.sv
// channel-4 i/o control: two control registers, four compare/capture slots, pins and interrupt
// assumes count and count_tick come from the channel counter on the same clock; pins are asynchronous
//
// Summary of operation
// - the high control register holds field b in bits 7..4 and field a in 3..0, the low one d in 7..4 and c in 3..0.
// - a field whose top bit is 0 makes its slot an output compare, 1 an input capture.
// - codes 0000 and 0100 leave the pin undriven, and every field resets to 0000.
// - codes 0001 and 0101 drive the pin low on a match, and bit 2 gives the level before the first match.
// - codes 0010 and 0110 drive the pin high on a match, starting from 0 or 1.
// - codes 0011 and 0111 invert the pin on a match, starting from 0 or 1.
// - codes 1000 and 1100 capture the counter on a rising edge of the slot's own pin.
// - codes 1001 and 1101 capture the counter on a falling edge of the pin.
// - codes 1010, 1011, 1110 and 1111 capture on both edges of the pin.
// - with buffer enable b set, slot d neither compares nor captures and its field has no effect.
// - with buffer enable a set, slot c neither compares nor captures and its field has no effect.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "timer_ch4_consts.svh"

module timer_ch4_io_control (
   input wire logic clock, // 25 MHz
   input wire logic reset_n, // async, active low
   input wire logic [`ADDR_W-1:0] addr, // register offset
   input wire logic [`DATA_W-1:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [`DATA_W-1:0] rdata, // read data, cycle after rd
   input wire logic [`CNT_W-1:0] count, // channel counter value
   input wire logic count_tick, // counter took a new value
   input wire logic [3:0] ch4_pin_in, // pin levels, bit 0 = a
   output logic [3:0] ch4_pin_out, // pin drive levels
   output logic [3:0] ch4_pin_oe, // pin drive enables
   output logic irq // level interrupt
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   timer_ch4_pkg::top_state_t s_r;
   timer_ch4_pkg::top_state_t s_nxt;

   logic [3:0] fields [`NUM_CH];
   logic [`NUM_CH-1:0] inhibit;
   logic [`NUM_CH-1:0] cap;
   logic [`NUM_CH-1:0] mat;
   logic [`NUM_CH-1:0] slot_out;
   logic [`NUM_CH-1:0] slot_oe;

   timer_ch4_chan_if ch_if [`NUM_CH] ();

   // ----------------------------------------
   // field decode
   // ----------------------------------------
   assign fields[`CH_A] = s_r.ctrl_hi[`FIELD_LO_MSB:0];
   assign fields[`CH_B] = s_r.ctrl_hi[`FIELD_HI_MSB:`FIELD_HI_LSB];
   assign fields[`CH_C] = s_r.ctrl_lo[`FIELD_LO_MSB:0];
   assign fields[`CH_D] = s_r.ctrl_lo[`FIELD_HI_MSB:`FIELD_HI_LSB];

   // buffer pairing: c backs a, d backs b
   assign inhibit[`CH_A] = 1'b0;
   assign inhibit[`CH_B] = 1'b0;
   assign inhibit[`CH_C] = s_r.mode[`MODE_BUF_A_BIT];
   assign inhibit[`CH_D] = s_r.mode[`MODE_BUF_B_BIT];

   // ----------------------------------------
   // slots
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < `NUM_CH; g++) begin : g_slot
         assign ch_if[g].field = fields[g];
         assign ch_if[g].inhibit = inhibit[g];
         assign ch_if[g].count = count;
         assign ch_if[g].count_tick = count_tick;
         assign ch_if[g].value = s_r.regs[g*`DATA_W +: `DATA_W];
         // only the second stage reaches the slot's edge logic
         assign ch_if[g].pin_in = s_r.sync2[g];
         assign cap[g] = ch_if[g].capture;
         assign mat[g] = ch_if[g].match;
         assign slot_out[g] = ch_if[g].pin_out;
         assign slot_oe[g] = ch_if[g].pin_oe;

         timer_ch4_chan u_chan (
            .clock(clock),
            .reset_n(reset_n),
            .port(ch_if[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.sync1 = ch4_pin_in;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.rdata = '0;

      // software writes
      if (wr) begin
         unique case (addr)
            `OFS_IO_CTRL_HIGH: s_nxt.ctrl_hi = wdata[7:0];
            `OFS_IO_CTRL_LOW: s_nxt.ctrl_lo = wdata[7:0];
            `OFS_MODE: s_nxt.mode = wdata[1:0];
            `OFS_REG_A: s_nxt.regs[`CH_A*`DATA_W +: `DATA_W] = wdata;
            `OFS_REG_B: s_nxt.regs[`CH_B*`DATA_W +: `DATA_W] = wdata;
            `OFS_REG_C: s_nxt.regs[`CH_C*`DATA_W +: `DATA_W] = wdata;
            `OFS_REG_D: s_nxt.regs[`CH_D*`DATA_W +: `DATA_W] = wdata;
            `OFS_MASK: s_nxt.mask = wdata[7:0];
            default: s_nxt.mask = s_r.mask;
         endcase
      end

      // reads; status clears on read
      if (rd) begin
         unique case (addr)
            `OFS_IO_CTRL_HIGH: s_nxt.rdata = {8'h00, s_r.ctrl_hi};
            `OFS_IO_CTRL_LOW: s_nxt.rdata = {8'h00, s_r.ctrl_lo};
            `OFS_MODE: s_nxt.rdata = {14'h0, s_r.mode};
            `OFS_REG_A: s_nxt.rdata = s_r.regs[`CH_A*`DATA_W +: `DATA_W];
            `OFS_REG_B: s_nxt.rdata = s_r.regs[`CH_B*`DATA_W +: `DATA_W];
            `OFS_REG_C: s_nxt.rdata = s_r.regs[`CH_C*`DATA_W +: `DATA_W];
            `OFS_REG_D: s_nxt.rdata = s_r.regs[`CH_D*`DATA_W +: `DATA_W];
            `OFS_STATUS: begin
               s_nxt.rdata = {8'h00, s_r.status};
               s_nxt.status = `RST_STATUS;
            end
            `OFS_MASK: s_nxt.rdata = {8'h00, s_r.mask};
            `OFS_PIN_STATE: s_nxt.rdata = {8'h00, slot_oe, s_r.sync2};
            default: s_nxt.rdata = '0;
         endcase
      end

      // hardware capture beats a same-cycle software write
      for (int i = 0; i < `NUM_CH; i++) begin
         if (cap[i]) begin
            s_nxt.regs[i*`DATA_W +: `DATA_W] = count;
         end
      end

      // events set after the read clear so a coincident event survives
      s_nxt.status = s_nxt.status | {cap, mat};
      s_nxt.irq = |(s_nxt.status & s_nxt.mask);
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s_r.ctrl_hi <= `RST_CTRL;
         s_r.ctrl_lo <= `RST_CTRL;
         s_r.mode <= `RST_MODE;
         s_r.regs <= '0;
         s_r.status <= `RST_STATUS;
         s_r.mask <= `RST_MASK;
         s_r.sync1 <= '0;
         s_r.sync2 <= '0;
         s_r.rdata <= '0;
         s_r.irq <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // pin levels and enables come straight from the slot flops
   assign ch4_pin_out = slot_out;
   assign ch4_pin_oe = slot_oe;
   assign rdata = s_r.rdata;
   assign irq = s_r.irq;

endmodule // timer_ch4_io_control

// ===== timer_ch4_pins_model.sv
// pin model outside the block: loops the block's drive back, else the bench's level
// assumes the bench changes ext_level right after a clock edge
`timescale 1ns/1ps

module timer_ch4_pins_model (
   input wire logic [3:0] ext_level, // outside driver level
   input wire logic [3:0] ch4_pin_out, // block drive level
   input wire logic [3:0] ch4_pin_oe, // block drive enable
   output logic [3:0] ch4_pin_in // resolved pin levels
);
   // ------------------------------
   // pin resolution
   // ------------------------------
   // each slot sees its own pin only
   assign ch4_pin_in = (ch4_pin_oe & ch4_pin_out) | (~ch4_pin_oe & ext_level);
endmodule // timer_ch4_pins_model

// ===== timer_ch4_io_control_properties.sv
// port checker for the channel-4 i/o control block
// assumes the consts header is on the include path
`timescale 1ns/1ps
`include "timer_ch4_consts.svh"

module timer_ch4_io_control_properties (
   input wire logic clock, // clock
   input wire logic reset_n, // async reset
   input wire logic [`ADDR_W-1:0] addr, // offset
   input wire logic [`DATA_W-1:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic [`DATA_W-1:0] rdata, // read data
   input wire logic [`CNT_W-1:0] count, // counter
   input wire logic count_tick, // counter step
   input wire logic [3:0] ch4_pin_in, // pin levels
   input wire logic [3:0] ch4_pin_out, // drive levels
   input wire logic [3:0] ch4_pin_oe, // drive enables
   input wire logic irq // interrupt
);
   // ------------------------------
   // properties
   // ------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   wire logic hi_wr = wr && addr == `OFS_IO_CTRL_HIGH;
   wire logic mode_wr = wr && addr == `OFS_MODE;
   sequence s_calm;
      (!wr && !count_tick) [*2];
   endsequence
   sequence s_nowr;
      (!wr) [*2];
   endsequence

   ctrl_readback_a: assert property (hi_wr ##2 rd && addr == `OFS_IO_CTRL_HIGH
      |=> rdata == {8'h00, $past(wdata[7:0], 3)})
      else $error("control readback wrong");
   out_disabled_a: assert property (hi_wr && (wdata[3] || wdata[1:0] == 2'h0)
      ##1 s_nowr |-> !ch4_pin_oe[0])
      else $error("pin driven while disabled");
   init_level_a: assert property (hi_wr && !wdata[3] && wdata[1:0] != 2'h0 ##1 s_calm
      |-> ch4_pin_oe[0] && ch4_pin_out[0] == $past(wdata[2], 2))
      else $error("initial pin level wrong");
   tick_gated_a: assert property (s_calm |=> $stable(ch4_pin_out))
      else $error("pin moved without match");
   pin_state_a: assert property (rd && addr == `OFS_PIN_STATE |=> rdata[7:4] == $past(ch4_pin_oe))
      else $error("pin state read wrong");
   unmapped_zero_a: assert property (rd && addr > `OFS_PIN_STATE |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
   buf_c_off_a: assert property (mode_wr && wdata[0] ##1 s_nowr |-> !ch4_pin_oe[2])
      else $error("buffered slot c drives");
   buf_d_off_a: assert property (mode_wr && wdata[1] ##1 s_nowr |-> !ch4_pin_oe[3])
      else $error("buffered slot d drives");
endmodule // timer_ch4_io_control_properties

bind timer_ch4_io_control timer_ch4_io_control_properties i_props (.clock, .reset_n, .addr, .wdata, .wr, .rd,
   .rdata, .count, .count_tick, .ch4_pin_in, .ch4_pin_out, .ch4_pin_oe, .irq);

// ===== testbench.sv
// self-checking bench for the channel-4 i/o control block
// assumes the design, pin model and checker files are compiled before it
`timescale 1ns/1ps
`include "timer_ch4_consts.svh"

module testbench;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] count = 16'h0000;
   logic count_tick = 1'b0;
   logic [3:0] ext_level = 4'h0;
   logic [15:0] rdata;
   logic [3:0] pin_in, pin_out, pin_oe;
   logic irq;
   logic [15:0] v, e1;
   logic [3:0] c;
   logic oe, lvl;
   int n_mismatch = 0;
   int n_checks = 0;

   always #20 clock = ~clock;

   timer_ch4_io_control i_dut (.clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .count(count), .count_tick(count_tick), .ch4_pin_in(pin_in), .ch4_pin_out(pin_out),
      .ch4_pin_oe(pin_oe), .irq(irq));
   timer_ch4_pins_model i_pins (.ext_level(ext_level), .ch4_pin_out(pin_out), .ch4_pin_oe(pin_oe),
      .ch4_pin_in(pin_in));

   // ------------------------------
   // bus and checking tasks
   // ------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      n_checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      rd_reg(`OFS_IO_CTRL_LOW, v);
      check(v, 16'h0000);
      check(16'(pin_oe), 16'h0000);
      wr_reg(`OFS_REG_A, 16'h0010);
      for (int k = 0; k < 8; k++) begin
         c = k[3:0];
         oe = c[1:0] != 2'h0;
         wr_reg(`OFS_IO_CTRL_HIGH, {12'h000, c});
         rd_reg(`OFS_IO_CTRL_HIGH, v);
         check(v, {12'h000, c});
         check(16'({pin_oe[0], pin_out[0] & pin_oe[0]}), 16'({oe, c[2] & oe}));
         @(posedge clock);
         count <= 16'h0011;
         count_tick <= 1'b1;
         @(posedge clock);
         count <= 16'h0010;
         @(posedge clock);
         count_tick <= 1'b0;
         lvl = (c[1:0] == 2'h1) ? 1'b0 : (c[1:0] == 2'h2) ? 1'b1 : !c[2];
         #1 check(16'({pin_oe[0], pin_out[0] & pin_oe[0]}), 16'({oe, lvl & oe}));
      end
      check(16'(irq), 16'h0000);
      wr_reg(`OFS_MASK, 16'h0001);
      @(posedge clock);
      #1 check(16'(irq), 16'h0001);
      rd_reg(`OFS_STATUS, v);
      check(v, 16'h0001);
      repeat (2) @(posedge clock);
      #1 check(16'(irq), 16'h0000);
      for (int k = 8; k < 16; k++) begin
         c = k[3:0];
         wr_reg(`OFS_REG_B, 16'h0000);
         wr_reg(`OFS_IO_CTRL_HIGH, {8'h00, c, 4'h0});
         @(posedge clock);
         count <= {12'h010, c};
         ext_level[1] <= 1'b1;
         repeat (4) @(posedge clock);
         rd_reg(`OFS_REG_B, v);
         e1 = (c[1] || !c[0]) ? {12'h010, c} : 16'h0000;
         check(v, e1);
         @(posedge clock);
         count <= {12'h020, c};
         ext_level[1] <= 1'b0;
         repeat (4) @(posedge clock);
         rd_reg(`OFS_REG_B, v);
         check(v, (c[1] || c[0]) ? {12'h020, c} : e1);
      end
      // only slot b captured since the last clear
      rd_reg(`OFS_STATUS, v);
      check(v, 16'h0020);
      wr_reg(`OFS_IO_CTRL_LOW, 16'h0083);
      repeat (2) @(posedge clock);
      #1 check(16'(pin_oe[2]), 16'h0001);
      wr_reg(`OFS_MODE, 16'h0003);
      rd_reg(`OFS_MODE, v);
      check(v, 16'h0003);
      check(16'(pin_oe[2]), 16'h0000);
      @(posedge clock);
      ext_level[3] <= 1'b1;
      repeat (4) @(posedge clock);
      rd_reg(`OFS_REG_D, v);
      check(v, 16'h0000);
      rd_reg(`OFS_PIN_STATE, v);
      check(v, 16'h0008);
      rd_reg(4'hF, v);
      check(v, 16'h0000);
      stop_test;
   end

   initial begin
      repeat (5000) @(posedge clock);
      n_mismatch++;
      stop_test;
   end
endmodule // testbench
